/* shared/ebt_pkg.sv */
// package: register map, field layouts and encodings of the 8-bit timer
package ebt_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int unsigned EBT_ADR_W = 10;
    localparam logic [7:0] EBT_IDX_COUNT = 8'hea;
    localparam logic [7:0] EBT_IDX_CTRL = 8'heb;
    localparam logic [7:0] EBT_IDX_CCTL = 8'hec;
    localparam logic [7:0] EBT_IDX_CMPV = 8'hed;
    localparam logic [7:0] EBT_IDX_FLAGS = 8'hf0;

    // ------------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] EBT_COUNT_RST = 8'h00;
    localparam logic [7:0] EBT_CTRL_RST = 8'h08;
    localparam logic [7:0] EBT_CCTL_RST = 8'h40;
    localparam logic [7:0] EBT_CMPV_RST = 8'h00;
    localparam logic [7:0] EBT_COUNT_MAX = 8'hff;
    localparam int unsigned EBT_CLR_BIT = 2;
    localparam int unsigned EBT_FLAG_OVF_BIT = 0;
    localparam int unsigned EBT_FLAG_CH0_BIT = 1;
    localparam int unsigned EBT_PRE_W = 7;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EBT_MODE_FREE = 2'h0,
        EBT_MODE_DOWN = 2'h1,
        EBT_MODE_MOD = 2'h2,
        EBT_MODE_UPDN = 2'h3
    } ebt_mode_t;

    typedef enum logic [2:0] {
        EBT_ACT_SET = 3'h0,
        EBT_ACT_CLR = 3'h1,
        EBT_ACT_TGL = 3'h2,
        EBT_ACT_SET_UP = 3'h3,
        EBT_ACT_CLR_UP = 3'h4,
        EBT_ACT_SET_MAX = 3'h5,
        EBT_ACT_CLR_ZERO = 3'h6,
        EBT_ACT_NONE = 3'h7
    } ebt_act_t;

    typedef struct packed {
        logic [2:0] div;
        logic run;
        logic ovf_mask;
        logic clr;
        ebt_mode_t mode;
    } ebt_ctrl_t;

    typedef struct packed {
        logic unused;
        logic irq_mask;
        ebt_act_t act;
        logic cmp_en;
        logic [1:0] rsvd;
    } ebt_cctl_t;

endpackage

/* design/ebt_prescaler.sv */
// module: tick prescaler producing counter update enables
`timescale 1ns/100ps
module ebt_prescaler
    import ebt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic [2:0] div_i,
    output logic upd_o
);
    import ebt_pkg::*;

    logic [EBT_PRE_W-1:0] pre_reg;
    logic [EBT_PRE_W-1:0] pre_next;
    wire [EBT_PRE_W:0] mask_wide;
    wire [EBT_PRE_W-1:0] div_mask;
    wire div_done;

    // ------------------------------------------------------------------
    // free-running tick count
    // ------------------------------------------------------------------
    // the divider is decoded from div_i each cycle, so a new setting
    // shapes the very next enable with no wait for a wrap
    assign mask_wide = ({{EBT_PRE_W{1'b0}}, 1'b1} << div_i) - 8'h01;
    assign div_mask = mask_wide[EBT_PRE_W-1:0];
    assign div_done = (pre_reg & div_mask) == div_mask; // RL3
    assign upd_o = tick_i & div_done; // RL2
    assign pre_next = tick_i ? pre_reg + 7'h01 : pre_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_reg <= 7'h00;
        end else begin
            pre_reg <= pre_next;
        end
    end

    chk_div_one_rate : assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        (div_i == 3'h0 && tick_i) |-> upd_o) // RL2
        else $error("undivided tick gave no update");

endmodule

/* design/ebt_timer.sv */
// module: 8-bit timer with one compare channel and wishbone registers
//
// Functional notes
// RL1 - 8-bit count readable by software, not writable, resets to zero
// RL2 - control bits 7:5 divide tick rate by 2^n, /1 to /128
// RL3 - new prescaler setting changes update rate immediately
// RL4 - run bit 4, reset 0: 0 suspends counting, 1 counts
// RL5 - overflow mask bit 3, reset 1, gates overflow interrupt request
// RL6 - writing 1 to clear bit 2 zeroes counter; reads as 0
// RL7 - clear bit reads 0 after return from deepest sleep modes
// RL8 - mode 00 counts freely 0 to 255 and wraps
// RL9 - mode 01 counts down from compare value to zero
// RL10 - mode 10 counts 0 up to compare value, restarts at zero
// RL11 - mode 11 counts up to compare value, then down to zero
// RL12 - channel mask bit 6, reset 1, gates channel interrupt request
// RL13 - bits 5:3 choose output action on compare match
// RL14 - codes 000/001/010 set, clear, toggle on match; 111 unused
// RL15 - 011 sets on up match, clears at zero or down match
// RL16 - 100 clears on up match, sets at zero or down match
// RL17 - 101 sets on match, clears when counter reaches 255
// RL18 - 110 clears on match, sets when counter reaches zero
// RL19 - compare enable bit 2, reset 0, switches compare operation
// RL20 - software writes zeros to compare control bits 1:0
// RL21 - 8-bit compare value register, reset zero, also mode limit
// RL22 - separate overflow and compare pending flags; writing 1 ignored
`timescale 1ns/100ps
module ebt_timer
    import ebt_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic TICK_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ebt_pkg::EBT_ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic CH0_OUT_O,
    output logic OVF_IRQ_O,
    output logic CH0_IRQ_O
);
    import ebt_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic dir_reg;
    logic dir_next;
    ebt_ctrl_t ctrl_reg;
    ebt_ctrl_t ctrl_next;
    ebt_cctl_t cctl_reg;
    ebt_cctl_t cctl_next;
    logic [7:0] cmpv_reg;
    logic [7:0] cmpv_next;
    logic ovf_flag_reg;
    logic ovf_flag_next;
    logic ch0_flag_reg;
    logic ch0_flag_next;
    logic out_reg;
    logic out_next;
    logic ack_reg;
    logic [7:0] rdat_reg;
    logic [7:0] rd_mux;
    logic ovf_ev;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire req = WB_CYC_I & WB_STB_I;
    wire take = req & ack_reg;
    wire [7:0] idx = WB_ADR_I[EBT_ADR_W-1:2];
    wire [7:0] wdat = WB_DAT_I[7:0];
    wire wr = take & WB_WE_I & WB_SEL_I[0];
    wire wr_ctrl = wr & (idx == EBT_IDX_CTRL);
    wire wr_cctl = wr & (idx == EBT_IDX_CCTL);
    wire wr_cmpv = wr & (idx == EBT_IDX_CMPV);
    wire wr_flags = wr & (idx == EBT_IDX_FLAGS);
    wire clr_wr = wr_ctrl & wdat[EBT_CLR_BIT]; // RL6

    // ------------------------------------------------------------------
    // counter events
    // ------------------------------------------------------------------
    wire upd;
    wire step = upd & ctrl_reg.run; // RL4
    wire at_zero = cnt_reg == EBT_COUNT_RST;
    wire at_max = cnt_reg == EBT_COUNT_MAX;
    wire at_cmp = cnt_reg == cmpv_reg;
    wire updn = ctrl_reg.mode == EBT_MODE_UPDN;
    wire cmp_on = cctl_reg.cmp_en; // RL19
    wire hit = step & cmp_on & at_cmp; // RL13
    wire hit_up = hit & ~dir_reg;
    wire hit_dn = hit & dir_reg;
    wire zero_ev = step & cmp_on & at_zero;
    wire max_ev = step & cmp_on & at_max;

    ebt_prescaler u_pre (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .tick_i(TICK_I),
        .div_i(ctrl_reg.div),
        .upd_o(upd)
    );

    // ------------------------------------------------------------------
    // count sequencing
    // ------------------------------------------------------------------
    // up/down rests one period at each end so both turning matches occur
    always_comb begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        ovf_ev = 1'b0;
        if (clr_wr) begin
            cnt_next = EBT_COUNT_RST; // RL6
            dir_next = 1'b0;
        end else if (step) begin
            case (ctrl_reg.mode)
                EBT_MODE_FREE: begin
                    cnt_next = cnt_reg + 8'h01; // RL8
                    ovf_ev = at_max;
                end
                EBT_MODE_DOWN: begin
                    if (at_zero) begin
                        cnt_next = cmpv_reg; // RL9
                        ovf_ev = 1'b1;
                    end else begin
                        cnt_next = cnt_reg - 8'h01; // RL9
                    end
                end
                EBT_MODE_MOD: begin
                    if (at_cmp) begin
                        cnt_next = EBT_COUNT_RST; // RL10
                        ovf_ev = 1'b1;
                    end else begin
                        cnt_next = cnt_reg + 8'h01; // RL10
                    end
                end
                EBT_MODE_UPDN: begin
                    if (!dir_reg) begin
                        if (at_cmp) begin
                            dir_next = 1'b1; // RL11
                        end else begin
                            cnt_next = cnt_reg + 8'h01;
                        end
                    end else if (at_zero) begin
                        dir_next = 1'b0; // RL11
                        ovf_ev = 1'b1;
                    end else begin
                        cnt_next = cnt_reg - 8'h01; // RL11
                    end
                end
                default: begin
                    cnt_next = cnt_reg;
                end
            endcase
        end
        if (!updn) begin
            dir_next = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // compare output
    // ------------------------------------------------------------------
    // a match is applied after the zero or 255 action, so a compare value
    // sitting on that end lets the match win
    always_comb begin
        out_next = out_reg;
        case (cctl_reg.act)
            EBT_ACT_SET: begin
                if (hit) out_next = 1'b1; // RL14
            end
            EBT_ACT_CLR: begin
                if (hit) out_next = 1'b0; // RL14
            end
            EBT_ACT_TGL: begin
                if (hit) out_next = ~out_reg; // RL14
            end
            EBT_ACT_SET_UP: begin
                if (updn) begin
                    if (hit_dn) out_next = 1'b0; // RL15
                    if (hit_up) out_next = 1'b1;
                end else begin
                    if (zero_ev) out_next = 1'b0; // RL15
                    if (hit) out_next = 1'b1;
                end
            end
            EBT_ACT_CLR_UP: begin
                if (updn) begin
                    if (hit_dn) out_next = 1'b1; // RL16
                    if (hit_up) out_next = 1'b0;
                end else begin
                    if (zero_ev) out_next = 1'b1; // RL16
                    if (hit) out_next = 1'b0;
                end
            end
            EBT_ACT_SET_MAX: begin
                if (max_ev) out_next = 1'b0; // RL17
                if (hit) out_next = 1'b1; // RL17
            end
            EBT_ACT_CLR_ZERO: begin
                if (zero_ev) out_next = 1'b1; // RL18
                if (hit) out_next = 1'b0; // RL18
            end
            default: begin
                out_next = out_reg;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    // the clear bit is never stored, so it reads 0 in every state,
    // including after any sleep and wake cycle
    always_comb begin
        ctrl_next = ctrl_reg;
        cctl_next = cctl_reg;
        cmpv_next = cmpv_reg;
        if (wr_ctrl) begin
            ctrl_next = ebt_ctrl_t'(wdat); // RL2 RL4 RL5
            ctrl_next.clr = 1'b0; // RL7
        end
        if (wr_cctl) begin
            cctl_next = ebt_cctl_t'(wdat); // RL12 RL13 RL19
            cctl_next.unused = 1'b0;
        end
        if (wr_cmpv) begin
            cmpv_next = wdat; // RL21
        end
    end

    // set wins over a software clear in the same cycle
    assign ovf_flag_next = ovf_ev |
        (ovf_flag_reg & ~(wr_flags & ~wdat[EBT_FLAG_OVF_BIT])); // RL22
    assign ch0_flag_next = hit |
        (ch0_flag_reg & ~(wr_flags & ~wdat[EBT_FLAG_CH0_BIT])); // RL22

    always_comb begin
        case (idx)
            EBT_IDX_COUNT: rd_mux = cnt_reg; // RL1
            EBT_IDX_CTRL: rd_mux = ctrl_reg;
            EBT_IDX_CCTL: rd_mux = cctl_reg;
            EBT_IDX_CMPV: rd_mux = cmpv_reg;
            EBT_IDX_FLAGS: rd_mux = {6'h00, ch0_flag_reg, ovf_flag_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cnt_reg <= EBT_COUNT_RST; // RL1
            dir_reg <= 1'b0;
            ctrl_reg <= ebt_ctrl_t'(EBT_CTRL_RST);
            cctl_reg <= ebt_cctl_t'(EBT_CCTL_RST);
            cmpv_reg <= EBT_CMPV_RST;
            ovf_flag_reg <= 1'b0;
            ch0_flag_reg <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            dir_reg <= dir_next;
            ctrl_reg <= ctrl_next;
            cctl_reg <= cctl_next;
            cmpv_reg <= cmpv_next;
            ovf_flag_reg <= ovf_flag_next;
            ch0_flag_reg <= ch0_flag_next;
            out_reg <= out_next;
        end
    end

    // one wait state: data is captured as ack rises, writes land on the
    // edge that samples ack
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ack_reg <= 1'b0;
            rdat_reg <= 8'h00;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (req & ~ack_reg) begin
                rdat_reg <= rd_mux;
            end
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = {24'h000000, rdat_reg};
    assign CH0_OUT_O = out_reg;
    assign OVF_IRQ_O = ovf_flag_reg & ctrl_reg.ovf_mask; // RL5
    assign CH0_IRQ_O = ch0_flag_reg & cctl_reg.irq_mask; // RL12

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_N_I);

    wire wr_count = wr & (idx == EBT_IDX_COUNT);

    chk_clear_zeroes_count : assert property ( // RL6
        clr_wr |=> (cnt_reg == 8'h00) && !dir_reg)
        else $error("clear write did not zero the counter");

    chk_count_not_written : assert property ( // RL1
        (wr_count && !step) |=> $stable(cnt_reg))
        else $error("counter changed on a write to its address");

    chk_free_wrap : assert property ( // RL8
        (step && !clr_wr && ctrl_reg.mode == EBT_MODE_FREE && at_max)
        |=> cnt_reg == 8'h00 && ovf_flag_reg)
        else $error("free running counter failed to wrap");

    chk_down_step : assert property ( // RL9
        (step && !clr_wr && ctrl_reg.mode == EBT_MODE_DOWN && !at_zero)
        |=> cnt_reg == $past(cnt_reg) - 8'h01)
        else $error("down counter did not decrement");

    chk_modulo_restart : assert property ( // RL10
        (step && !clr_wr && ctrl_reg.mode == EBT_MODE_MOD && at_cmp)
        |=> cnt_reg == 8'h00)
        else $error("modulo counter did not restart at limit");

    chk_updown_turn : assert property ( // RL11
        (step && !clr_wr && updn && !dir_reg && at_cmp)
        |=> dir_reg && cnt_reg == $past(cmpv_reg))
        else $error("up/down counter did not turn at limit");

    chk_suspend_holds : assert property ( // RL4
        (!ctrl_reg.run && !clr_wr) |=> $stable(cnt_reg))
        else $error("counter moved while suspended");

    chk_ovf_irq_gate : assert property ( // RL5
        (ovf_ev && ctrl_reg.ovf_mask && !wr_ctrl) |=> OVF_IRQ_O)
        else $error("unmasked overflow raised no request");

    chk_ch0_irq_gate : assert property ( // RL12
        (hit && cctl_reg.irq_mask && !wr_cctl) |=> CH0_IRQ_O)
        else $error("unmasked compare raised no request");

    chk_set_on_match : assert property ( // RL14
        (hit && cctl_reg.act == EBT_ACT_SET) |=> CH0_OUT_O)
        else $error("set action left output low");

    chk_max_clears : assert property ( // RL17
        (max_ev && !hit && cctl_reg.act == EBT_ACT_SET_MAX)
        |=> !CH0_OUT_O)
        else $error("output not cleared at 255");

    chk_compare_off : assert property ( // RL19
        !cmp_on |=> $stable(CH0_OUT_O) && !$rose(ch0_flag_reg))
        else $error("compare acted while disabled");

    chk_clr_reads_zero : assert property ( // RL7
        (req && !ack_reg && !WB_WE_I && idx == EBT_IDX_CTRL)
        |=> WB_ACK_O && WB_DAT_O[EBT_CLR_BIT] == 1'b0)
        else $error("clear bit read back as one");

    chk_flag_w1_keeps : assert property ( // RL22
        (wr_flags && ovf_flag_reg && wdat[EBT_FLAG_OVF_BIT])
        |=> ovf_flag_reg)
        else $error("writing one disturbed the overflow flag");

    chk_ack_one_wait : assert property (
        (req && !ack_reg) |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("bus ack not a single pulse after one wait");

    cov_updown_cycle : cover property (
        step && updn && dir_reg && at_zero);
    cov_toggle_match : cover property (
        hit && cctl_reg.act == EBT_ACT_TGL);
    cov_flag_race : cover property (
        ovf_ev && wr_flags && !wdat[EBT_FLAG_OVF_BIT]);
    cov_down_reload : cover property (
        step && ctrl_reg.mode == EBT_MODE_DOWN && at_zero);

endmodule

/* verification/ebt_timer_tb.sv */
// testbench: self-checking bench for the 8-bit timer with compare channel
`timescale 1ns/100ps
module ebt_timer_tb;
import ebt_pkg::*;
logic clk;
logic rst_n;
logic tick;
logic cyc;
logic stb;
logic we;
logic [EBT_ADR_W-1:0] adr;
logic [3:0] sel;
logic [31:0] wdat;
logic [31:0] rdat;
logic [31:0] rq;
logic ack;
logic out;
logic ovf_irq;
logic ch_irq;
int bad_count;
int cmp_count;
int m_cnt, m_dir, m_out, m_flags, m_ctrl, m_cctl, m_cmp, m_pre;
int a;

ebt_timer ebt_timer_i (
    .CLOCK_I(clk), .RST_N_I(rst_n), .TICK_I(tick),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CH0_OUT_O(out), .OVF_IRQ_O(ovf_irq), .CH0_IRQ_O(ch_irq)
);

initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
end

// ------------------------------------------------------------------
// checking and closing
// ------------------------------------------------------------------
task results();
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask

task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
        bad_count++;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask

// ------------------------------------------------------------------
// reference model
// ------------------------------------------------------------------
function automatic int exp_reg(input logic [7:0] idx);
    case (idx)
        EBT_IDX_COUNT: return m_cnt;
        EBT_IDX_CTRL: return m_ctrl;
        EBT_IDX_CCTL: return m_cctl;
        EBT_IDX_CMPV: return m_cmp;
        EBT_IDX_FLAGS: return m_flags;
        default: return 0;
    endcase
endfunction

task model_wr(input logic [7:0] idx, input logic [7:0] d);
    case (idx)
        EBT_IDX_CTRL: begin
            m_ctrl = d & 8'hfb;
            if (d[EBT_CLR_BIT]) begin
                m_cnt = 0;
                m_dir = 0;
            end
            if (d[1:0] != 2'h3) m_dir = 0;
        end
        EBT_IDX_CCTL: m_cctl = d & 8'h7f;
        EBT_IDX_CMPV: m_cmp = d;
        EBT_IDX_FLAGS: m_flags = m_flags & d & 3;
        default: ;
    endcase
endtask

// one tick: prescaler always advances, counter only on its update
task step();
    int msk, mode, act, old, dn, mt, ov;
    msk = (1 << ((m_ctrl >> 5) & 7)) - 1;
    mode = m_ctrl & 3;
    act = (m_cctl >> 3) & 7;
    old = m_cnt;
    dn = m_dir;
    ov = 0;
    if ((m_pre & msk) != msk || ((m_ctrl >> 4) & 1) == 0) begin
        m_pre = (m_pre + 1) % 128;
        return;
    end
    m_pre = (m_pre + 1) % 128;
    mt = ((m_cctl >> 2) & 1) && m_cnt == m_cmp;
    case (mode)
        0: begin
            ov = m_cnt == 255;
            m_cnt = (m_cnt + 1) % 256;
        end
        1: if (m_cnt == 0) begin
            ov = 1;
            m_cnt = m_cmp;
        end else m_cnt--;
        2: if (m_cnt == m_cmp) begin
            ov = 1;
            m_cnt = 0;
        end else m_cnt = (m_cnt + 1) % 256;
        default: if (!m_dir) begin
            if (m_cnt == m_cmp) m_dir = 1;
            else m_cnt++;
        end else if (m_cnt == 0) begin
            m_dir = 0;
            ov = 1;
        end else m_cnt--;
    endcase
    if (ov) m_flags |= 1;
    if (mt) begin
        m_flags |= 2;
        case (act)
            0, 5: m_out = 1;
            1, 6: m_out = 0;
            2: m_out = !m_out;
            3: m_out = (mode == 3 && dn) ? 0 : 1;
            4: m_out = (mode == 3 && dn) ? 1 : 0;
            default: ;
        endcase
    end else if ((m_cctl >> 2) & 1) begin
        // for actions 3 and 4, up/down replaces the zero action by the downward match
        if (act == 3 && old == 0 && mode != 3) m_out = 0;
        if (((act == 4 && mode != 3) || act == 6) && old == 0) m_out = 1;
        if (act == 5 && old == 255) m_out = 0;
    end
endtask

// ------------------------------------------------------------------
// bus master and tick driver
// ------------------------------------------------------------------
task wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
        input logic [3:0] s);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    wdat <= {24'h000000, d};
    i = 0;
    do begin
        @(posedge clk);
        i++;
    end while (ack !== 1'b1 && i < 64);
    if (i >= 64) begin
        bad_count++;
        results();
    end
    rq = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (w && s[0]) model_wr(idx, d);
endtask

task rd(input logic [7:0] idx);
    wb(1'b0, idx, 8'h00, 4'h1);
    check(rq, exp_reg(idx));
endtask

task ticks(input int n);
    repeat (n) begin
        @(posedge clk);
        tick <= 1'b1;
        step();
    end
    @(posedge clk);
    tick <= 1'b0;
    repeat (2) @(posedge clk);
    rd(EBT_IDX_COUNT);
    check(out, m_out);
endtask

// ------------------------------------------------------------------
// main sequence
// ------------------------------------------------------------------
initial begin
    tick = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'h0;
    wdat = 32'h00000000;
    rst_n = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    {m_cnt, m_dir, m_out, m_flags, m_cmp, m_pre} = '0;
    m_ctrl = 8'h08;
    m_cctl = 8'h40;
    void'($urandom(32'he08f));
    repeat (12) @(posedge clk);
    check({ack, out, ovf_irq, ch_irq}, 0);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(EBT_IDX_COUNT);
    rd(EBT_IDX_CTRL);
    rd(EBT_IDX_CCTL);
    rd(EBT_IDX_CMPV);
    rd(EBT_IDX_FLAGS);
    $display("test reset values done");
    wb(1'b1, EBT_IDX_COUNT, 8'h5a, 4'h1);
    rd(EBT_IDX_COUNT);
    wb(1'b1, EBT_IDX_CCTL, 8'hfc, 4'h1);
    rd(EBT_IDX_CCTL);
    wb(1'b1, EBT_IDX_CMPV, 8'h3c, 4'h0);
    rd(EBT_IDX_CMPV);
    wb(1'b1, EBT_IDX_CMPV, 8'($urandom), 4'h1);
    rd(EBT_IDX_CMPV);
    wb(1'b1, 8'he0, 8'hff, 4'h1);
    rd(8'he0);
    wb(1'b1, EBT_IDX_CTRL, 8'h0c, 4'h1);
    rd(EBT_IDX_CTRL);
    wb(1'b1, EBT_IDX_CCTL, 8'h40, 4'h1);
    $display("test register access done");
    for (a = 0; a < 8; a++) begin
        wb(1'b1, EBT_IDX_CTRL, 8'((a << 5) | 8'h10), 4'h1);
        ticks(1 + $urandom % 150);
    end
    wb(1'b1, EBT_IDX_CTRL, 8'h00, 4'h1);
    ticks(128);
    $display("test prescaler and run done");
    wb(1'b1, EBT_IDX_CTRL, 8'h1c, 4'h1);
    ticks(260);
    rd(EBT_IDX_FLAGS);
    check(ovf_irq, m_flags & 1);
    wb(1'b1, EBT_IDX_FLAGS, 8'hff, 4'h1);
    rd(EBT_IDX_FLAGS);
    wb(1'b1, EBT_IDX_CTRL, 8'h10, 4'h1);
    // the mask lands on the ack edge; look one cycle later
    @(posedge clk);
    check(ovf_irq, 1'b0);
    wb(1'b1, EBT_IDX_FLAGS, 8'h00, 4'h1);
    rd(EBT_IDX_FLAGS);
    $display("test overflow done");
    for (a = 1; a < 4; a++) begin
        repeat (2) begin
            wb(1'b1, EBT_IDX_CMPV, 8'(1 + $urandom % 20), 4'h1);
            wb(1'b1, EBT_IDX_CTRL, 8'(8'h14 | a), 4'h1);
            ticks(5 + $urandom % 60);
        end
    end
    wb(1'b1, EBT_IDX_FLAGS, 8'h00, 4'h1);
    $display("test counting modes done");
    for (a = 0; a < 8; a++) begin
        wb(1'b1, EBT_IDX_CCTL, 8'(8'h44 | (a << 3)), 4'h1);
        wb(1'b1, EBT_IDX_CMPV, 8'($urandom), 4'h1);
        wb(1'b1, EBT_IDX_CTRL, 8'h18, 4'h1);
        ticks(1 + $urandom % 300);
        rd(EBT_IDX_FLAGS);
        check(ch_irq, (m_flags >> 1) & 1);
    end
    wb(1'b1, EBT_IDX_CCTL, 8'h14, 4'h1);
    @(posedge clk);
    check(ch_irq, 1'b0);
    for (a = 3; a < 5; a++) begin
        wb(1'b1, EBT_IDX_CCTL, 8'(8'h44 | (a << 3)), 4'h1);
        wb(1'b1, EBT_IDX_CMPV, 8'(1 + $urandom % 10), 4'h1);
        wb(1'b1, EBT_IDX_CTRL, 8'h1f, 4'h1);
        ticks(10 + $urandom % 40);
    end
    wb(1'b1, EBT_IDX_CCTL, 8'h50, 4'h1);
    // start from clear flags so a compare flag set while disabled shows
    wb(1'b1, EBT_IDX_FLAGS, 8'h00, 4'h1);
    ticks(300);
    rd(EBT_IDX_FLAGS);
    $display("test compare actions done");
    results();
end
endmodule
